// ---- tioc_top.v ----
// Overview of operation
// - select bit3 low is compare; action 00 disables pin, 01 drives low on match.
// - compare with action 10 drives the pin high on each match.
// - compare with action 11 toggles the pin on each match.
// - select bit2 sets the pin's initial level before the first match.
// - capture role, bit2 low, action 00: capture on pin rising edge.
// - capture role, bit2 low, action 01: capture on pin falling edge.
// - capture role, bit2 low, bit1 high: capture on both edges.
// - channel 3 A and C, bits 3 and 2 set: capture on channel 4 count.
// - channel 4 A, bits 3 and 2 set: capture on channel 3 A match or capture.
// - buffer-a enable set makes the C select void, no compare or capture.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "tioc_defs.vh"
module tioc_top #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // counters from the wider timer unit
  input wire [WIDTH-1:0] chan3_counter,
  input wire [WIDTH-1:0] chan4_counter,
  input wire chan4_count_step,
  // timer pins, input side unsynchronised
  input wire chan3_pin_a_in,
  output wire chan3_pin_a_out,
  output wire chan3_pin_a_oe,
  input wire chan3_pin_c_in,
  output wire chan3_pin_c_out,
  output wire chan3_pin_c_oe,
  input wire chan4_pin_a_in,
  output wire chan4_pin_a_out,
  output wire chan4_pin_a_oe,
  // interrupt
  output wire irq
);
  // software-visible registers
  reg [7:0] chan3_io_select_high_q;
  reg [7:0] chan3_io_select_low_q;
  reg [7:0] chan4_io_select_q;
  reg [7:0] chan3_mode_reg_q;
  reg [5:0] stat_q;
  reg [5:0] stat_d;
  reg [5:0] mask_q;

  // pin synchronisers
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;

  // write request holding, address and data may arrive apart
  reg [7:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;

  // initial-level load strobes
  reg [2:0] sel_wr_q;

  // read decode and handshakes
  reg [31:0] rd_d;
  reg rd_hit;
  wire wr_fire;
  wire rd_fire;
  wire wr_hit;

  // per-register results
  wire [WIDTH-1:0] gra3;
  wire [WIDTH-1:0] grc3;
  wire [WIDTH-1:0] gra4;
  wire m_a3;
  wire m_c3;
  wire m_a4;
  wire c_a3;
  wire c_c3;
  wire c_a4;
  wire buf_a;
  wire [5:0] events;

  // per-register write strobes
  wire wr_sel3h;
  wire wr_sel3l;
  wire wr_sel4;
  wire wr_gra3;
  wire wr_grc3;
  wire wr_gra4;
  wire stat_rd;

  // pin inputs pass two flops before any logic
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {chan4_pin_a_in, chan3_pin_c_in, chan3_pin_a_in};
      sync2_q <= sync1_q;
    end
  end

  // write channel: address and data taken in either order
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
  assign wr_fire = aw_have_q & w_have_q;
  assign wr_hit = (awaddr_q[1:0] == 2'h0) && (awaddr_q <= `TIOC_OFS_MASK);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TIOC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // counter is read only, unmapped gets slverr
        s_axi_bresp <= wr_hit ? `TIOC_RESP_OKAY : `TIOC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // write strobes per register, low byte lanes only
  assign wr_sel3h = wr_fire && awaddr_q == `TIOC_OFS_SEL3H && wstrb_q[0];
  assign wr_sel3l = wr_fire && awaddr_q == `TIOC_OFS_SEL3L && wstrb_q[0];
  assign wr_sel4 = wr_fire && awaddr_q == `TIOC_OFS_SEL4 && wstrb_q[0];
  assign wr_gra3 = wr_fire && awaddr_q == `TIOC_OFS_GRA3 && (&wstrb_q[1:0]);
  assign wr_grc3 = wr_fire && awaddr_q == `TIOC_OFS_GRC3 && (&wstrb_q[1:0]);
  assign wr_gra4 = wr_fire && awaddr_q == `TIOC_OFS_GRA4 && (&wstrb_q[1:0]);

  // select strobes delayed one edge: the stored select then already
  // holds the new level bit when the pin takes its initial level
  always @(posedge aclk)
  begin
    if (!aresetn)
      sel_wr_q <= 3'h0;
    else
      sel_wr_q <= {wr_sel4, wr_sel3l, wr_sel3h};
  end

  // configuration registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chan3_io_select_high_q <= `TIOC_SEL_RST;
      chan3_io_select_low_q <= `TIOC_SEL_RST;
      chan4_io_select_q <= `TIOC_SEL_RST;
      chan3_mode_reg_q <= `TIOC_MODE_RST;
      mask_q <= 6'h00;
    end
    else if (wr_fire)
    begin
      if (wr_sel3h)
        chan3_io_select_high_q <= {4'h0, wdata_q[3:0]};
      if (wr_sel3l)
        chan3_io_select_low_q <= {4'h0, wdata_q[3:0]};
      if (wr_sel4)
        chan4_io_select_q <= {4'h0, wdata_q[3:0]};
      if (awaddr_q == `TIOC_OFS_MODE3 && wstrb_q[0])
        chan3_mode_reg_q <= wdata_q[7:0];
      if (awaddr_q == `TIOC_OFS_MASK && wstrb_q[0])
        mask_q <= wdata_q[5:0];
    end
  end

  // buffer mode voids the c register
  assign buf_a = chan3_mode_reg_q[`TIOC_MODE_BFA];

  // channel 3 register a: alternate source is channel 4 counting
  tioc_chan #(.WIDTH(WIDTH)) u_a3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(chan3_io_select_high_q[3:0]),
    .inhibit(1'b0),
    .sel_wr(sel_wr_q[0]),
    .count(chan3_counter),
    .pin_sync(sync2_q[0]),
    .alt_trig(chan4_count_step),
    .gr_wr(wr_gra3),
    .gr_wdata(wdata_q[WIDTH-1:0]),
    .gr_q(gra3),
    .pin_out_q(chan3_pin_a_out),
    .pin_oe(chan3_pin_a_oe),
    .match(m_a3),
    .capture(c_a3)
  );

  // channel 3 register c: void while it buffers register a
  tioc_chan #(.WIDTH(WIDTH)) u_c3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(chan3_io_select_low_q[3:0]),
    .inhibit(buf_a),
    .sel_wr(sel_wr_q[1]),
    .count(chan3_counter),
    .pin_sync(sync2_q[1]),
    .alt_trig(chan4_count_step),
    .gr_wr(wr_grc3),
    .gr_wdata(wdata_q[WIDTH-1:0]),
    .gr_q(grc3),
    .pin_out_q(chan3_pin_c_out),
    .pin_oe(chan3_pin_c_oe),
    .match(m_c3),
    .capture(c_c3)
  );

  // channel 4 register a: chained to channel 3 register a events
  tioc_chan #(.WIDTH(WIDTH)) u_a4 (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(chan4_io_select_q[3:0]),
    .inhibit(1'b0),
    .sel_wr(sel_wr_q[2]),
    .count(chan4_counter),
    .pin_sync(sync2_q[2]),
    .alt_trig(m_a3 | c_a3),
    .gr_wr(wr_gra4),
    .gr_wdata(wdata_q[WIDTH-1:0]),
    .gr_q(gra4),
    .pin_out_q(chan4_pin_a_out),
    .pin_oe(chan4_pin_a_oe),
    .match(m_a4),
    .capture(c_a4)
  );

  // sticky status; a match lasts while counter holds, so set is level
  assign events = {c_a4, m_a4, c_c3, m_c3, c_a3, m_a3};
  // a read of the status word clears it
  assign stat_rd = rd_fire && s_axi_araddr == `TIOC_OFS_STAT;

  // read clears, a new event in the same cycle wins
  always @*
  begin
    stat_d = stat_q;
    if (stat_rd)
      stat_d = 6'h00;
    stat_d = stat_d | events;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      stat_q <= 6'h00;
    else
      stat_q <= stat_d;
  end

  // level interrupt while any unmasked status bit stands
  assign irq = |(stat_q & mask_q);

  // read channel: one read at a time, answer next cycle
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  // read decode
  always @*
  begin
    rd_d = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `TIOC_OFS_SEL3H: rd_d[7:0] = chan3_io_select_high_q;
      `TIOC_OFS_SEL3L: rd_d[7:0] = chan3_io_select_low_q;
      `TIOC_OFS_SEL4: rd_d[7:0] = chan4_io_select_q;
      `TIOC_OFS_MODE3: rd_d[7:0] = chan3_mode_reg_q;
      `TIOC_OFS_GRA3: rd_d[WIDTH-1:0] = gra3;
      `TIOC_OFS_GRC3: rd_d[WIDTH-1:0] = grc3;
      `TIOC_OFS_GRA4: rd_d[WIDTH-1:0] = gra4;
      `TIOC_OFS_STAT: rd_d[5:0] = stat_q;
      `TIOC_OFS_MASK: rd_d[5:0] = mask_q;
      `TIOC_OFS_CNT: rd_d[WIDTH-1:0] = chan3_counter;
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TIOC_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_hit ? `TIOC_RESP_OKAY : `TIOC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// ---- tioc_defs.vh ----
`ifndef TIOC_DEFS_VH
`define TIOC_DEFS_VH
// register byte offsets
`define TIOC_OFS_SEL3H 8'h00
`define TIOC_OFS_SEL3L 8'h04
`define TIOC_OFS_SEL4 8'h08
`define TIOC_OFS_MODE3 8'h0C
`define TIOC_OFS_GRA3 8'h10
`define TIOC_OFS_GRC3 8'h14
`define TIOC_OFS_GRA4 8'h18
`define TIOC_OFS_STAT 8'h1C
`define TIOC_OFS_MASK 8'h20
`define TIOC_OFS_CNT 8'h24
// select field bits
`define TIOC_SEL_ROLE 3
`define TIOC_SEL_LEVEL 2
`define TIOC_SEL_ACT_HI 1
`define TIOC_SEL_ACT_LO 0
// action codes
`define TIOC_ACT_OFF 2'h0
`define TIOC_ACT_LOW 2'h1
`define TIOC_ACT_HIGH 2'h2
`define TIOC_ACT_TOGGLE 2'h3
// mode register: buffer-a enable bit
`define TIOC_MODE_BFA 4
// reset values
`define TIOC_SEL_RST 8'h00
`define TIOC_MODE_RST 8'h00
`define TIOC_GR_RST 16'hFFFF
// axi responses
`define TIOC_RESP_OKAY 2'h0
`define TIOC_RESP_SLVERR 2'h2
`endif

// ---- tioc_chan.v ----
`timescale 1ns/100ps
`default_nettype none
`include "tioc_defs.vh"
// one general register: compare or capture per 4-bit select
module tioc_chan #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // configuration
  input wire [3:0] sel,
  input wire inhibit,
  input wire sel_wr,
  // counter and trigger sources
  input wire [WIDTH-1:0] count,
  input wire pin_sync,
  input wire alt_trig,
  // software load of the general register
  input wire gr_wr,
  input wire [WIDTH-1:0] gr_wdata,
  // results
  output reg [WIDTH-1:0] gr_q,
  output reg pin_out_q,
  output wire pin_oe,
  output wire match,
  output wire capture
);
  reg pin_prev_q;
  wire role_cap;
  wire [1:0] act;
  wire rise;
  wire fall;
  wire pin_trig;
  assign role_cap = sel[`TIOC_SEL_ROLE];
  assign act = sel[1:0];
  assign rise = pin_sync & ~pin_prev_q;
  assign fall = ~pin_sync & pin_prev_q;
  // pin edge decode; bit 0 ignored for both edges
  assign pin_trig = sel[`TIOC_SEL_ACT_HI] ? (rise | fall) :
    (sel[`TIOC_SEL_ACT_LO] ? fall : rise);
  // buffered register generates nothing
  assign match = ~inhibit & ~role_cap & (count == gr_q);
  assign capture = ~inhibit & role_cap &
    (sel[`TIOC_SEL_LEVEL] ? alt_trig : pin_trig);
  // pin driven only while compare action enabled
  assign pin_oe = ~inhibit & ~role_cap & (act != `TIOC_ACT_OFF);

  // edge history
  always @(posedge aclk)
  begin
    if (!aresetn)
      pin_prev_q <= 1'b0;
    else
      pin_prev_q <= pin_sync;
  end

  // general register: software write, capture wins over write
  always @(posedge aclk)
  begin
    if (!aresetn)
      gr_q <= {WIDTH{1'b1}};
    else if (capture)
      gr_q <= count;
    else if (gr_wr)
      gr_q <= gr_wdata;
  end

  // output level: initial level on select write, then match actions
  always @(posedge aclk)
  begin
    if (!aresetn)
      pin_out_q <= 1'b0;
    else if (sel_wr)
      pin_out_q <= sel[`TIOC_SEL_LEVEL];
    else if (match)
    begin
      case (act)
        `TIOC_ACT_LOW: pin_out_q <= 1'b0;
        `TIOC_ACT_HIGH: pin_out_q <= 1'b1;
        `TIOC_ACT_TOGGLE: pin_out_q <= ~pin_out_q;
        default: pin_out_q <= pin_out_q;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tioc_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
// port-level checks on bus handshakes, pin enables and interrupt
module tioc_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pin enables and interrupt
  input wire logic chan3_pin_a_oe,
  input wire logic chan3_pin_c_oe,
  input wire logic chan4_pin_a_oe,
  input wire logic irq
);
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // answers stand until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
  // no new request while an answer is pending
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken during response");
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("read taken during response");
  // answer latency as handed over
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
  // enables follow the selects, which move only with a write
  property p_oe_cause;
    $changed({chan3_pin_a_oe, chan3_pin_c_oe, chan4_pin_a_oe}) |-> $rose(s_axi_bvalid);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
  property p_rst_quiet;
    $rose(aresetn) |-> !irq && !chan3_pin_a_oe && !chan3_pin_c_oe && !chan4_pin_a_oe;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  c_irq: cover property ($rose(irq));
  c_oe: cover property ($rose(chan3_pin_a_oe));
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind tioc_top tioc_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .chan3_pin_a_oe, .chan3_pin_c_oe,
  .chan4_pin_a_oe, .irq);
`default_nettype wire

// ---- tioc_far.sv ----
`timescale 1ns/100ps
`default_nettype none
// far side: timer counters and the three pins
module tioc_far (
  // clock
  input wire logic aclk,
  // bench controls
  input wire logic run3,
  input wire logic run4,
  input wire logic [2:0] lvl,
  // toward the block
  output logic [15:0] chan3_counter = 16'h0100,
  output logic [15:0] chan4_counter = 16'h0200,
  output logic chan4_count_step,
  output logic [2:0] pin
);
  // counters hold while stopped, so captured values are known
  always @(posedge aclk)
  begin
    chan3_counter <= chan3_counter + {15'h0000, run3};
    chan4_counter <= chan4_counter + {15'h0000, run4};
  end
  // one step pulse per channel 4 count
  assign chan4_count_step = run4;
  // pins are driven push-pull from outside
  assign pin = lvl;
endmodule
`default_nettype wire

// ---- tioc_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tioc_tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, t;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, run3 = 1'h1, run4 = 1'h1;
  logic [2:0] lvl = 3'h0;
  logic [1:0] resp;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] chan3_counter, chan4_counter;
  wire logic chan4_count_step;
  wire logic [2:0] pin, pout, poe;
  int n_tests = 0, n_mismatch = 0, cyc = 0;
  tioc_far far (.aclk, .run3, .run4, .lvl, .chan3_counter, .chan4_counter,
    .chan4_count_step, .pin);
  // strobes stay full: every register is one whole word
  tioc_top #(.WIDTH(16)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .chan3_counter, .chan4_counter, .chan4_count_step,
    .chan3_pin_a_in(pin[0]), .chan3_pin_a_out(pout[0]), .chan3_pin_a_oe(poe[0]),
    .chan3_pin_c_in(pin[1]), .chan3_pin_c_out(pout[1]), .chan3_pin_c_oe(poe[1]),
    .chan4_pin_a_in(pin[2]), .chan4_pin_a_out(pout[2]), .chan4_pin_a_oe(poe[2]), .irq);
  task automatic results;
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!s_axi_bvalid)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!s_axi_rvalid)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    resp = s_axi_rresp;
    chk("rdata", e & m, s_axi_rdata & m);
  endtask
  // one channel 4 count step, then time for the capture to land
  task automatic step;
    run4 <= 1'h1;
    @(posedge aclk);
    run4 <= 1'h0;
    repeat (4) @(posedge aclk);
  endtask
  initial
    forever #5 aclk = ~aclk;
  // ceiling against a hung handshake
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results;
    end
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    // reset values and refused places
    rd(8'h00, 0);
    rd(8'h10, 32'hFFFF);
    rd(8'h28, 0, 0);
    chk("rresp", 2, resp);
    wr(8'h24, 0);
    chk("bresp", 2, resp);
    $display("test map done");
    // every compare code: enable, initial level, action at the match
    for (int k = 0; k < 3; k++)
      for (int c = 0; c < 8; c++)
      begin
        t = (k == 2 ? chan4_counter : chan3_counter) + 16'h0028;
        wr(16 + 4 * k, t);
        wr(4 * k, c);
        // initial level lands one edge after the select is stored
        @(posedge aclk);
        chk("oe", c[1:0] != 0, poe[k]);
        if (c[1:0] != 0)
          chk("init", c[2], pout[k]);
        repeat (40) @(posedge aclk);
        if (c[1:0] != 0)
          chk("act", c[1:0] == 1 ? 0 : c[1:0] == 2 ? 1 : !c[2], pout[k]);
      end
    $display("test compare done");
    // pin-edge capture with counters frozen
    run3 <= 1'h0;
    run4 <= 1'h0;
    for (int k = 0; k < 3; k++)
      for (int c = 8; c < 12; c++)
      begin
        wr(4 * k, c);
        for (int e = 1; e >= 0; e--)
        begin
          wr(16 + 4 * k, 0);
          lvl[k] <= e[0];
          repeat (6) @(posedge aclk);
          rd(16 + 4 * k, c == 8 + e ? 0 : k == 2 ? chan4_counter : chan3_counter);
        end
      end
    $display("test capture done");
    // count-step capture on channel 3, chained capture on channel 4
    for (int k = 0; k < 3; k++)
    begin
      wr(4 * k, 12);
      wr(16 + 4 * k, 0);
    end
    t = chan4_counter;
    step;
    rd(8'h10, chan3_counter);
    rd(8'h14, chan3_counter);
    rd(8'h18, t);
    rd(8'h24, chan3_counter);
    // buffer mode voids the c select
    wr(8'h0C, 32'h10);
    rd(8'h0C, 32'h10);
    wr(8'h04, 2);
    chk("oe_c", 0, poe[1]);
    wr(8'h04, 12);
    wr(8'h14, 0);
    step;
    rd(8'h14, 0);
    wr(8'h0C, 0);
    $display("test sources done");
    // interrupt: masked event, unmask, clear on read
    wr(8'h20, 0);
    rd(8'h1C, 0, 0);
    step;
    chk("irq", 0, irq);
    wr(8'h20, 2);
    chk("irq", 1, irq);
    rd(8'h1C, 2, 2);
    chk("irq", 0, irq);
    $display("test irq done");
    results;
  end
endmodule
`default_nettype wire
